// ===== core/hold_timer.sv
// Reports when a level has stood high for N consecutive cycles
`timescale 1ns/1ps
`default_nettype none
module hold_timer #(
	parameter int N = 1
) (
	// Clock and reset
	input  wire logic clk_in,
	input  wire logic rst_n_in,
	// Level in, qualified flag out
	hold_if.timer     tif
);
	localparam int W = $clog2(N + 1);

	typedef struct packed {
		logic [W-1:0] cnt;
	} hold_st_t;

	hold_st_t st_r;
	hold_st_t st_nxt;

	// Saturating count; any low cycle restarts the measurement
	always_comb
	begin
		st_nxt = st_r;
		if (!tif.level)
			st_nxt.cnt = '0;
		else if (st_r.cnt != W'(N))
			st_nxt.cnt = st_r.cnt + W'(1);
	end

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign tif.done = tif.level && (st_r.cnt == W'(N));
endmodule
`default_nettype wire

// ===== core/radio_mode_ctrl.sv
// Operating-mode controller of a packet radio transceiver
`timescale 1ns/1ps
`default_nettype none
module radio_mode_ctrl
	import radio_ctrl_pkg::*;
#(
	parameter int CD_CYC    = radio_ctrl_pkg::CD_MIN_CYC,
	parameter int STEP_CYC  = radio_ctrl_pkg::RETRY_STEP_CYC,
	parameter int ACK_CYC   = radio_ctrl_pkg::ACK_WAIT_CYC
) (
	// Clock and reset
	input  wire logic                              clk_in,
	input  wire logic                              rst_n_in,
	// Register port
	input  wire logic [radio_ctrl_pkg::ADDR_W-1:0] reg_addr_in,
	input  wire logic [radio_ctrl_pkg::DATA_W-1:0] reg_wdata_in,
	input  wire logic                              reg_wr_in,
	input  wire logic                              reg_rd_in,
	output logic      [radio_ctrl_pkg::DATA_W-1:0] reg_rdata_out,
	// Pins and radio front end levels
	input  wire logic                              activate_in,
	input  wire logic                              carrier_raw_in,
	// Transmit path events
	input  wire logic                              tx_fifo_empty_in,
	input  wire logic                              payload_written_in,
	input  wire logic                              tx_sent_in,
	input  wire logic                              tx_skip_ack_in,
	input  wire logic                              ack_received_in,
	// Receive path events
	input  wire logic                              rx_valid_in,
	input  wire logic                              rx_skip_ack_in,
	input  wire logic                              rx_fifo_full_in,
	// Mode and radio control
	output radio_ctrl_pkg::mode_t                  mode_out,
	output logic                                   tx_on_out,
	output logic                                   rx_on_out,
	output logic                                   ack_send_out,
	output logic                                   rx_store_out,
	output logic                                   rx_drop_out,
	output logic      [11:0]                       carrier_mhz_out,
	output logic                                   air_rate_2m_out,
	output logic                                   carrier_detect_out,
	output logic                                   irq_n_out
);
	import radio_ctrl_pkg::*;

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	localparam int TMR_W = 24;

	typedef struct packed {
		mode_t       mode;
		logic        power_up_bit;
		logic        role;
		logic        aa;
		logic        mask_rx;
		logic        mask_tx;
		logic        mask_rt;
		logic [6:0]  chan;
		logic        rate2m;
		logic [3:0]  limit;
		logic [3:0]  delay;
		logic [3:0]  rcnt;
		logic        f_rx;
		logic        f_tx;
		logic        f_rt;
		logic        ack_wait;
		logic        ack_tx;
		logic        retry_pend;
		logic [TMR_W-1:0] tmr;
		logic [3:0]  step;
		logic [7:0]  rdata;
		logic [11:0] freq;
		logic        store;
		logic        drop;
	} ctrl_st_t;

	ctrl_st_t st_r;
	ctrl_st_t st_nxt;

	// ------------------------------------------------------------
	// Pin synchronisers and hold-time qualifiers
	// ------------------------------------------------------------
	logic [1:0] pins_s;
	logic       ce_s;
	logic       carrier_s;
	logic       ce_long;
	logic       cd_level;

	hold_if ce_hold ();
	hold_if cd_hold ();

	sync2 #(
		.W (2)
	) u_sync (
		.clk_in   (clk_in),
		.rst_n_in (rst_n_in),
		.async_in ({carrier_raw_in, activate_in}),
		.sync_out (pins_s)
	);

	assign ce_s      = pins_s[0];
	assign carrier_s = pins_s[1];

	// Activate width measured on the internal clock
	assign ce_hold.level = ce_s;
	assign ce_long       = ce_hold.done;

	hold_timer #(
		.N (CE_MIN_CYC)
	) u_ce_hold (
		.clk_in   (clk_in),
		.rst_n_in (rst_n_in),
		.tif      (ce_hold.timer)
	);

	// Carrier only counts while listening; leaving receive restarts the filter
	assign cd_hold.level = carrier_s && (st_r.mode == MODE_RX) && !st_r.ack_wait;
	assign cd_level      = cd_hold.done;

	hold_timer #(
		.N (CD_CYC)
	) u_cd_hold (
		.clk_in   (clk_in),
		.rst_n_in (rst_n_in),
		.tif      (cd_hold.timer)
	);

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	logic  ev_rx;
	logic  ev_tx;
	logic  ev_rt;
	logic  wr_stat;
	mode_t after_tx;
	logic  step_end;

	// Mode after a finished transmit, shared by the normal and acknowledged paths
	always_comb
	begin
		if (!ce_s)
			after_tx = MODE_STBY1;
		else if (!tx_fifo_empty_in)
			after_tx = MODE_TX;
		else
			after_tx = MODE_STBY2;
	end

	assign step_end = (st_r.tmr == TMR_W'(STEP_CYC - 1));
	assign wr_stat  = reg_wr_in && (reg_addr_in == REG_STATUS);

	always_comb
	begin
		st_nxt       = st_r;
		st_nxt.store = 1'b0;
		st_nxt.drop  = 1'b0;
		st_nxt.rdata = 8'h00;
		ev_rx        = 1'b0;
		ev_tx        = 1'b0;
		ev_rt        = 1'b0;

		// Mode sequencing
		case (st_r.mode)
			MODE_DOWN:
			begin
				if (st_r.power_up_bit)
					st_nxt.mode = MODE_STBY1;
			end
			MODE_STBY1:
			begin
				if (st_r.retry_pend)
				begin
					// Retry delay is (delay+1) steps
					st_nxt.tmr = step_end ? '0 : st_r.tmr + TMR_W'(1);
					if (step_end)
					begin
						st_nxt.step = st_r.step + 4'h1;
						if (st_r.step == st_r.delay)
						begin
							st_nxt.step       = 4'h0;
							st_nxt.retry_pend = 1'b0;
							if (st_r.rcnt < st_r.limit)
							begin
								st_nxt.rcnt = st_r.rcnt + 4'h1;
								st_nxt.mode = MODE_TX;
							end
							else
								ev_rt = 1'b1;
						end
					end
				end
				else if (ce_s && st_r.role)
					st_nxt.mode = MODE_RX;
				else if (ce_s && !st_r.role)
				begin
					if (tx_fifo_empty_in)
						st_nxt.mode = MODE_STBY2;
					else if (ce_long)
					begin
						st_nxt.rcnt = 4'h0;
						st_nxt.mode = MODE_TX;
					end
				end
			end
			MODE_STBY2:
			begin
				if (!ce_s)
					st_nxt.mode = MODE_STBY1;
				else if (payload_written_in || !tx_fifo_empty_in)
				begin
					st_nxt.rcnt = 4'h0;
					st_nxt.mode = MODE_TX;
				end
			end
			MODE_TX:
			begin
				// Activate is ignored until the packet on air is finished
				if (tx_sent_in)
				begin
					if (st_r.ack_tx)
					begin
						st_nxt.ack_tx = 1'b0;
						st_nxt.mode   = MODE_RX;
					end
					else if (st_r.aa && !tx_skip_ack_in)
					begin
						st_nxt.ack_wait = 1'b1;
						st_nxt.tmr      = '0;
						st_nxt.mode     = MODE_RX;
					end
					else
					begin
						ev_tx       = 1'b1;
						st_nxt.mode = after_tx;
					end
				end
			end
			MODE_RX:
			begin
				if (st_r.ack_wait)
				begin
					if (ack_received_in)
					begin
						ev_tx           = 1'b1;
						st_nxt.ack_wait = 1'b0;
						st_nxt.mode     = after_tx;
					end
					else if (st_r.tmr == TMR_W'(ACK_CYC - 1))
					begin
						st_nxt.ack_wait   = 1'b0;
						st_nxt.retry_pend = 1'b1;
						st_nxt.tmr        = '0;
						st_nxt.step       = 4'h0;
						st_nxt.mode       = MODE_STBY1;
					end
					else
						st_nxt.tmr = st_r.tmr + TMR_W'(1);
				end
				else if (!ce_s)
					st_nxt.mode = MODE_STBY1;
				else if (rx_valid_in)
				begin
					if (rx_fifo_full_in)
						st_nxt.drop = 1'b1;
					else
					begin
						st_nxt.store = 1'b1;
						ev_rx        = 1'b1;
						if (st_r.aa && !rx_skip_ack_in)
						begin
							st_nxt.ack_tx = 1'b1;
							st_nxt.mode   = MODE_TX;
						end
					end
				end
				// Otherwise the receiver simply keeps listening
				else
					st_nxt.mode = MODE_RX;
			end
			default:
				st_nxt.mode = MODE_DOWN;
		endcase

		// Power-down overrides everything, even a packet in flight
		if (!st_r.power_up_bit)
		begin
			st_nxt.mode       = MODE_DOWN;
			st_nxt.ack_wait   = 1'b0;
			st_nxt.ack_tx     = 1'b0;
			st_nxt.retry_pend = 1'b0;
		end

		// Event flags: a set in the clearing cycle wins
		st_nxt.f_rx = (st_r.f_rx & ~(wr_stat & reg_wdata_in[STAT_RX_BIT])) | ev_rx;
		st_nxt.f_tx = (st_r.f_tx & ~(wr_stat & reg_wdata_in[STAT_TX_BIT])) | ev_tx;
		st_nxt.f_rt = (st_r.f_rt & ~(wr_stat & reg_wdata_in[STAT_RT_BIT])) | ev_rt;

		// Register writes, accepted in every mode
		if (reg_wr_in)
		begin
			case (reg_addr_in)
				REG_CONFIG:
				begin
					st_nxt.power_up_bit  = reg_wdata_in[CFG_PWR_BIT];
					st_nxt.role    = reg_wdata_in[CFG_ROLE_BIT];
					st_nxt.aa      = reg_wdata_in[CFG_AA_BIT];
					st_nxt.mask_rx = reg_wdata_in[CFG_MASK_RX_BIT];
					st_nxt.mask_tx = reg_wdata_in[CFG_MASK_TX_BIT];
					st_nxt.mask_rt = reg_wdata_in[CFG_MASK_RT_BIT];
				end
				REG_CHANNEL:
					st_nxt.chan = reg_wdata_in[6:0];
				REG_RATE:
					st_nxt.rate2m = reg_wdata_in[0];
				REG_RETRY:
				begin
					st_nxt.limit = reg_wdata_in[RETRY_LIM_LSB +: 4];
					st_nxt.delay = reg_wdata_in[RETRY_DLY_LSB +: 4];
				end
				default:
					st_nxt.chan = st_nxt.chan;
			endcase
		end

		// Carrier frequency tracks the channel number
		st_nxt.freq = BASE_MHZ + {5'h00, st_r.chan};

		// Read data stand for the one cycle after the strobe
		if (reg_rd_in)
		begin
			case (reg_addr_in)
				REG_CONFIG:
				begin
					st_nxt.rdata[CFG_PWR_BIT]     = st_r.power_up_bit;
					st_nxt.rdata[CFG_ROLE_BIT]    = st_r.role;
					st_nxt.rdata[CFG_AA_BIT]      = st_r.aa;
					st_nxt.rdata[CFG_MASK_RX_BIT] = st_r.mask_rx;
					st_nxt.rdata[CFG_MASK_TX_BIT] = st_r.mask_tx;
					st_nxt.rdata[CFG_MASK_RT_BIT] = st_r.mask_rt;
				end
				REG_CHANNEL:
					st_nxt.rdata = {1'b0, st_r.chan};
				REG_RATE:
					st_nxt.rdata = {7'h00, st_r.rate2m};
				REG_RETRY:
					st_nxt.rdata = {st_r.delay, st_r.limit};
				REG_STATUS:
				begin
					st_nxt.rdata[STAT_RX_BIT] = st_r.f_rx;
					st_nxt.rdata[STAT_TX_BIT] = st_r.f_tx;
					st_nxt.rdata[STAT_RT_BIT] = st_r.f_rt;
					st_nxt.rdata[STAT_CD_BIT] = cd_level;
				end
				REG_OBSERVE:
					st_nxt.rdata = {1'b0, st_r.mode, st_r.rcnt};
				default:
					st_nxt.rdata = 8'h00;
			endcase
		end
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			st_r         <= '0;
			st_r.mode    <= MODE_DOWN;
			st_r.power_up_bit  <= CONFIG_RST[CFG_PWR_BIT];
			st_r.role    <= CONFIG_RST[CFG_ROLE_BIT];
			st_r.aa      <= CONFIG_RST[CFG_AA_BIT];
			st_r.mask_rx <= CONFIG_RST[CFG_MASK_RX_BIT];
			st_r.mask_tx <= CONFIG_RST[CFG_MASK_TX_BIT];
			st_r.mask_rt <= CONFIG_RST[CFG_MASK_RT_BIT];
			st_r.chan    <= CHANNEL_RST;
			st_r.rate2m  <= RATE_RST;
			st_r.limit   <= LIMIT_RST;
			st_r.delay   <= DELAY_RST;
			st_r.freq    <= BASE_MHZ + {5'h00, CHANNEL_RST};
		end
		else
			st_r <= st_nxt;
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign mode_out           = st_r.mode;
	assign tx_on_out          = (st_r.mode == MODE_TX);
	assign rx_on_out          = (st_r.mode == MODE_RX);
	assign ack_send_out       = st_r.ack_tx;
	assign rx_store_out       = st_r.store;
	assign rx_drop_out        = st_r.drop;
	assign carrier_mhz_out    = st_r.freq;
	assign air_rate_2m_out    = st_r.rate2m;
	assign carrier_detect_out = cd_level;
	assign reg_rdata_out      = st_r.rdata;

	// Any unmasked flag pulls the line low
	assign irq_n_out = !((st_r.f_rx & !st_r.mask_rx) |
		(st_r.f_tx & !st_r.mask_tx) |
		(st_r.f_rt & !st_r.mask_rt));
endmodule
`default_nettype wire

// ===== core/sync2.sv
// Two-stage synchroniser for asynchronous level inputs
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clk_in,
	input  wire logic         rst_n_in,
	// Levels
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} sync_st_t;

	sync_st_t st_r;
	sync_st_t st_nxt;

	// First stage feeds only the second stage
	always_comb
	begin
		st_nxt.s1 = async_in;
		st_nxt.s2 = st_r.s1;
	end

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign sync_out = st_r.s2;
endmodule
`default_nettype wire

// ===== pkg/hold_if.sv
// Level-and-done pair between a user and a hold-time qualifier
`timescale 1ns/1ps
`default_nettype none
interface hold_if;
	logic level;
	logic done;
	modport owner (output level, input done);
	modport timer (input level, output done);
endinterface
`default_nettype wire

// ===== pkg/radio_ctrl_pkg.sv
// Shared constants and types of the radio operating-mode controller
`default_nettype none
package radio_ctrl_pkg;

	// ------------------------------------------------------------
	// Register port geometry and offsets
	// ------------------------------------------------------------
	localparam int          ADDR_W      = 3;
	localparam int          DATA_W      = 8;
	localparam logic [2:0]  REG_CONFIG  = 3'h0;
	localparam logic [2:0]  REG_CHANNEL = 3'h1;
	localparam logic [2:0]  REG_RATE    = 3'h2;
	localparam logic [2:0]  REG_RETRY   = 3'h3;
	localparam logic [2:0]  REG_STATUS  = 3'h4;
	localparam logic [2:0]  REG_OBSERVE = 3'h5;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int CFG_PWR_BIT     = 0;
	localparam int CFG_ROLE_BIT    = 1;
	localparam int CFG_AA_BIT      = 2;
	localparam int CFG_MASK_RX_BIT = 4;
	localparam int CFG_MASK_TX_BIT = 5;
	localparam int CFG_MASK_RT_BIT = 6;
	localparam int STAT_RX_BIT     = 0;
	localparam int STAT_TX_BIT     = 1;
	localparam int STAT_RT_BIT     = 2;
	localparam int STAT_CD_BIT     = 3;
	localparam int RETRY_LIM_LSB   = 0;
	localparam int RETRY_DLY_LSB   = 4;
	localparam int OBS_MODE_LSB    = 4;

	// ------------------------------------------------------------
	// Reset values and carrier base
	// ------------------------------------------------------------
	localparam logic [7:0]  CONFIG_RST  = 8'h00;
	localparam logic [6:0]  CHANNEL_RST = 7'h02;
	localparam logic        RATE_RST    = 1'b1;
	localparam logic [3:0]  LIMIT_RST   = 4'h3;
	localparam logic [3:0]  DELAY_RST   = 4'h0;
	localparam logic [11:0] BASE_MHZ    = 12'h960;

	// ------------------------------------------------------------
	// Timing, 50 MHz clock
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 20;
	localparam int CE_MIN_NS     = 10000;
	localparam int CE_MIN_CYC    = CE_MIN_NS / CLK_PERIOD_NS + 1;
	localparam int CD_MIN_NS     = 128000;
	localparam int CD_MIN_CYC    = (CD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RETRY_STEP_NS = 250000;
	localparam int RETRY_STEP_CYC = RETRY_STEP_NS / CLK_PERIOD_NS;
	localparam int ACK_WAIT_NS   = 250000;
	localparam int ACK_WAIT_CYC  = ACK_WAIT_NS / CLK_PERIOD_NS;

	// ------------------------------------------------------------
	// Operating modes
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		MODE_DOWN,
		MODE_STBY1,
		MODE_STBY2,
		MODE_TX,
		MODE_RX
	} mode_t;

endpackage
`default_nettype wire

// ===== tb/link_model.sv
// Far-side link model: ends packets on air and answers acknowledge waits
`timescale 1ns/1ps
`default_nettype none
module link_model (
	// Clock and reset
	input  wire logic clk_in,
	input  wire logic rst_n_in,
	// Radio state and bench control
	input  wire logic tx_on_in,
	input  wire logic rx_on_in,
	input  wire logic ack_reply_in,
	// Link events
	output logic      sent_out,
	output logic      ack_out
);
	logic [4:0] cnt_r;

	// ----------------------------------------
	// Airtime counter
	// ----------------------------------------
	// A packet lasts 20 cycles; an ack comes 6 cycles into a wait, only when asked
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			cnt_r <= 5'h00;
			sent_out <= 1'b0;
			ack_out <= 1'b0;
		end
		else
		begin
			cnt_r <= (tx_on_in || rx_on_in) && !sent_out && !ack_out ? cnt_r + 5'h01 : 5'h00;
			sent_out <= tx_on_in && cnt_r == 5'h13;
			ack_out <= rx_on_in && ack_reply_in && cnt_r == 5'h05;
		end
	end
endmodule
`default_nettype wire

// ===== tb/radio_mode_ctrl_monitor.sv
// Port-level assertions for the radio mode controller
`timescale 1ns/1ps
`default_nettype none
module radio_mode_ctrl_monitor
	import radio_ctrl_pkg::*;
#(
	parameter int CD_CYC = 20
) (
	// Clock and reset
	input wire logic                                 clk_in,
	input wire logic                                 rst_n_in,
	// Register port
	input wire logic [radio_ctrl_pkg::ADDR_W-1:0]    reg_addr_in,
	input wire logic [radio_ctrl_pkg::DATA_W-1:0]    reg_wdata_in,
	input wire logic                                 reg_wr_in,
	// Pins and events
	input wire logic                                 activate_in,
	input wire logic                                 carrier_raw_in,
	input wire logic                                 tx_sent_in,
	input wire logic                                 rx_valid_in,
	input wire logic                                 rx_skip_ack_in,
	input wire logic                                 rx_fifo_full_in,
	// Outputs
	input wire radio_ctrl_pkg::mode_t                mode_out,
	input wire logic                                 tx_on_out,
	input wire logic                                 rx_on_out,
	input wire logic                                 ack_send_out,
	input wire logic                                 rx_store_out,
	input wire logic                                 rx_drop_out,
	input wire logic [11:0]                          carrier_mhz_out,
	input wire logic                                 air_rate_2m_out,
	input wire logic                                 carrier_detect_out
);
	int hi_cnt_r;
	int cd_cnt_r;

	default clocking dc @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);

	// Raw run lengths; the synchronisers only delay them, so they bound the design's
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			hi_cnt_r <= 0;
			cd_cnt_r <= 0;
		end
		else
		begin
			hi_cnt_r <= activate_in ? hi_cnt_r + 1 : 0;
			cd_cnt_r <= carrier_raw_in && rx_on_out ? cd_cnt_r + 1 : 0;
		end
	end

	// ----------------------------------------
	// Properties
	// ----------------------------------------
	a_power_down: assert property (
		reg_wr_in && reg_addr_in == REG_CONFIG && !reg_wdata_in[CFG_PWR_BIT]
		|-> ##2 mode_out == MODE_DOWN) else $error("mode not down");
	a_carrier_follows: assert property (
		reg_wr_in && reg_addr_in == REG_CHANNEL
		|-> ##2 carrier_mhz_out == 12'h960 + {5'h00, $past(reg_wdata_in[6:0], 2)})
		else $error("carrier frequency wrong");
	a_rate_follows: assert property (
		reg_wr_in && reg_addr_in == REG_RATE |-> ##2 air_rate_2m_out == $past(reg_wdata_in[0], 2))
		else $error("air rate wrong");
	a_store_has_room: assert property (
		rx_store_out |-> $past(rx_valid_in) && !$past(rx_fifo_full_in)) else $error("bad store");
	a_drop_when_full: assert property (
		rx_drop_out |-> $past(rx_valid_in) && $past(rx_fifo_full_in) && !rx_store_out)
		else $error("bad drop");
	a_ack_needs_flag: assert property (
		$rose(ack_send_out) |-> $past(rx_valid_in) && !$past(rx_skip_ack_in) && !$past(rx_fifo_full_in))
		else $error("ack without cause");
	a_ack_back_rx: assert property (
		ack_send_out && tx_sent_in |=> mode_out == MODE_RX && !ack_send_out)
		else $error("no return to receive");
	a_tx_holds: assert property (
		mode_out == MODE_TX && !tx_sent_in && !reg_wr_in && !$past(reg_wr_in) |=> mode_out == MODE_TX)
		else $error("left transmit early");
	a_cd_filter: assert property (
		$rose(carrier_detect_out) |-> cd_cnt_r >= CD_CYC) else $error("carrier detect early");
	a_ce_width: assert property (
		$rose(tx_on_out) && $past(mode_out) == MODE_STBY1 && $past(activate_in)
		|-> hi_cnt_r >= CE_MIN_CYC) else $error("short activate started transmit");
endmodule

bind radio_mode_ctrl radio_mode_ctrl_monitor #(.CD_CYC(CD_CYC)) u_radio_mode_ctrl_monitor (
	.clk_in, .rst_n_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .activate_in,
	.carrier_raw_in, .tx_sent_in, .rx_valid_in, .rx_skip_ack_in, .rx_fifo_full_in,
	.mode_out, .tx_on_out, .rx_on_out, .ack_send_out, .rx_store_out, .rx_drop_out,
	.carrier_mhz_out, .air_rate_2m_out, .carrier_detect_out
);
`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench of the radio operating-mode controller
`timescale 1ns/1ps
`default_nettype none
module tb;
	import radio_ctrl_pkg::*;
	logic        clk_in, rst_n_in, reg_wr_in, reg_rd_in, activate_in, carrier_raw_in;
	logic        tx_fifo_empty_in, payload_written_in, tx_sent_in, tx_skip_ack_in;
	logic        ack_received_in, rx_valid_in, rx_skip_ack_in, rx_fifo_full_in, ack_reply;
	logic        tx_on_out, rx_on_out, ack_send_out, rx_store_out, rx_drop_out;
	logic        air_rate_2m_out, carrier_detect_out, irq_n_out;
	logic [2:0]  reg_addr_in;
	logic [7:0]  reg_wdata_in, reg_rdata_out;
	logic [11:0] carrier_mhz_out;
	mode_t       mode_out;
	int          n_mismatch = 0;
	int          check_count = 0;
	int          cyc = 0;

	radio_mode_ctrl #(.CD_CYC(20), .STEP_CYC(10), .ACK_CYC(15)) u_radio_mode_ctrl (
		.clk_in, .rst_n_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
		.reg_rdata_out, .activate_in, .carrier_raw_in, .tx_fifo_empty_in,
		.payload_written_in, .tx_sent_in, .tx_skip_ack_in, .ack_received_in,
		.rx_valid_in, .rx_skip_ack_in, .rx_fifo_full_in, .mode_out, .tx_on_out,
		.rx_on_out, .ack_send_out, .rx_store_out, .rx_drop_out, .carrier_mhz_out,
		.air_rate_2m_out, .carrier_detect_out, .irq_n_out
	);
	link_model u_link_model (
		.clk_in, .rst_n_in, .tx_on_in(tx_on_out), .rx_on_in(rx_on_out),
		.ack_reply_in(ack_reply), .sent_out(tx_sent_in), .ack_out(ack_received_in)
	);

	// 50 MHz clock
	initial
	begin
		clk_in = 1'b0;
		forever #10 clk_in = ~clk_in;
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic finish_test;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		check_count++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Waits n edges, then lets the edge's updates settle
	task automatic w(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask
	task automatic wm(input mode_t e);
		for (int i = 0; i < 1000 && mode_out !== e; i++)
			w(1);
		chk(mode_out, e);
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_in <= 1'b1;
		@(posedge clk_in);
		reg_wr_in <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a, input logic [7:0] e);
		@(posedge clk_in);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge clk_in);
		reg_rd_in <= 1'b0;
		#1;
		chk(reg_rdata_out, e);
	endtask
	// Activate pin, FIFO empty level and skip-ack level in one step
	task automatic lv(input logic a, input logic e, input logic s);
		@(posedge clk_in);
		activate_in <= a;
		tx_fifo_empty_in <= e;
		tx_skip_ack_in <= s;
	endtask
	task automatic rxv(input logic sk, input logic fu);
		@(posedge clk_in);
		rx_skip_ack_in <= sk;
		rx_fifo_full_in <= fu;
		rx_valid_in <= 1'b1;
		@(posedge clk_in);
		rx_valid_in <= 1'b0;
		w(3);
	endtask

	// Hang guard: the sequence needs about 2200 cycles
	always @(posedge clk_in)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			n_mismatch++;
			finish_test();
		end
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		{reg_wr_in, reg_rd_in, activate_in, carrier_raw_in, payload_written_in} = '0;
		{tx_skip_ack_in, rx_valid_in, rx_skip_ack_in, rx_fifo_full_in, ack_reply} = '0;
		reg_addr_in = 3'h0;
		reg_wdata_in = 8'h00;
		tx_fifo_empty_in = 1'b1;
		rst_n_in = 1'b0;
		repeat (8) @(posedge clk_in);
		rst_n_in <= 1'b1;
		w(1);
		chk(mode_out, MODE_DOWN);
		chk(carrier_mhz_out, 12'h962);
		chk({air_rate_2m_out, irq_n_out}, 12'h003);
		// Registers stay reachable while powered down
		for (int c = 0; c < 128; c += 42)
		begin
			wr(REG_CHANNEL, 8'(c));
			w(2);
			chk(carrier_mhz_out, 12'h960 + 12'(c));
			rd(REG_CHANNEL, 8'(c));
		end
		wr(REG_RATE, 8'h00);
		w(2);
		chk(air_rate_2m_out, 12'h000);
		wr(REG_RATE, 8'h01);
		w(2);
		chk(air_rate_2m_out, 12'h001);
		rd(3'h6, 8'h00);
		wr(REG_RETRY, 8'h01);
		rd(REG_RETRY, 8'h01);
		// Transmitter without acknowledge
		wr(REG_CONFIG, 8'h01);
		w(2);
		chk(mode_out, MODE_STBY1);
		lv(1'b1, 1'b0, 1'b0);
		w(100);
		lv(1'b0, 1'b0, 1'b0);
		w(10);
		chk(mode_out, MODE_STBY1);
		lv(1'b1, 1'b0, 1'b0);
		w(400);
		chk(mode_out, MODE_STBY1);
		wm(MODE_TX);
		lv(1'b1, 1'b1, 1'b0);
		wm(MODE_STBY2);
		rd(REG_STATUS, 8'h02);
		chk(irq_n_out, 12'h000);
		wr(REG_STATUS, 8'h02);
		w(2);
		chk(irq_n_out, 12'h001);
		@(posedge clk_in);
		payload_written_in <= 1'b1;
		tx_fifo_empty_in <= 1'b0;
		@(posedge clk_in);
		payload_written_in <= 1'b0;
		wm(MODE_TX);
		for (int i = 0; i < 100 && tx_sent_in !== 1'b1; i++)
			w(1);
		w(2);
		chk(mode_out, MODE_TX);
		lv(1'b0, 1'b0, 1'b0);
		w(3);
		chk(mode_out, MODE_TX);
		wm(MODE_STBY1);
		// Acknowledged transmit, then a single retry without an answer
		// Clear the done flag left by the unacknowledged packets first
		wr(REG_STATUS, 8'h02);
		wr(REG_CONFIG, 8'h05);
		ack_reply <= 1'b1;
		lv(1'b1, 1'b0, 1'b0);
		wm(MODE_TX);
		lv(1'b0, 1'b0, 1'b0);
		wm(MODE_RX);
		rd(REG_STATUS, 8'h00);
		wm(MODE_STBY1);
		rd(REG_STATUS, 8'h02);
		wr(REG_STATUS, 8'h02);
		ack_reply <= 1'b0;
		lv(1'b1, 1'b0, 1'b0);
		wm(MODE_TX);
		lv(1'b0, 1'b0, 1'b0);
		w(200);
		rd(REG_OBSERVE, 8'h11);
		rd(REG_STATUS, 8'h04);
		chk(irq_n_out, 12'h000);
		wr(REG_STATUS, 8'h04);
		// Receiver with acknowledge
		wr(REG_CONFIG, 8'h07);
		lv(1'b1, 1'b1, 1'b0);
		wm(MODE_RX);
		rxv(1'b0, 1'b0);
		chk({mode_out, ack_send_out}, {MODE_TX, 1'b1});
		wm(MODE_RX);
		rd(REG_STATUS, 8'h01);
		wr(REG_STATUS, 8'h01);
		rxv(1'b0, 1'b1);
		chk(mode_out, MODE_RX);
		rd(REG_STATUS, 8'h00);
		rxv(1'b1, 1'b0);
		w(50);
		chk(mode_out, MODE_RX);
		@(posedge clk_in);
		carrier_raw_in <= 1'b1;
		w(10);
		chk(carrier_detect_out, 12'h000);
		w(30);
		chk(carrier_detect_out, 12'h001);
		lv(1'b0, 1'b1, 1'b0);
		w(5);
		chk(mode_out, MODE_STBY1);
		// Receiver without acknowledge, then power down
		wr(REG_CONFIG, 8'h03);
		lv(1'b1, 1'b1, 1'b0);
		wm(MODE_RX);
		rxv(1'b0, 1'b0);
		chk(mode_out, MODE_RX);
		wr(REG_CONFIG, 8'h00);
		w(2);
		chk(mode_out, MODE_DOWN);
		finish_test();
	end
endmodule
`default_nettype wire
